// File: ecu_cam_model.sv
// ecu_cam_model: stands in for the exposure, readout and trigger logic
// assumes the bench calls its tasks; the cc1 line idles low
`default_nettype none
module ecu_cam_model (
  input wire logic clk,
  output ecu_pkg::ecu_events_t events,
  output logic cc1
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet lines at start
  initial begin
    events = '0;
    cc1 = 1'b0;
  end
  // one-cycle pulse on event bit b
  task automatic pulse(input int b);
    @(posedge clk);
    events[b] <= 1'b1;
    @(posedge clk);
    events <= '0;
  endtask
  // new cc1 level, then room for the synchroniser
  task automatic line(input logic v);
    @(posedge clk);
    cc1 <= v;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: ecu_counter.sv
// ecu_counter: event counter with start, increment and clear sources
// assumes internal events are one-cycle pulses on clk; cc1 is an async pin
// Functional notes
// - start on chosen edge of cc1
// - increment selector; off holds count
// - internal events add one each
// - cc1 increments on matching edges
// - tick source adds one per microsecond
// - increment edge: rise, fall or any
// - end event when terminal count reached
// - after clear, wait for start again
// - clear source off: software clear only
// - internal events selectable as clear source
// - cc1 clears on matching edges
// - clear edge: rise, fall or any
// - disabled or active; configure when disabled
// - count up from zero to terminal
// - state idle, wait, active, done, overflow
// - capture count just before each clear
//
// Added by the designer: the register offsets and the address-and-strobe port.
`default_nettype none
module ecu_counter #(
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ecu_pkg::ecu_bus_req_t bus_req,
  output logic [ecu_pkg::ECU_DW-1:0] rdata,
  input wire ecu_pkg::ecu_events_t events,
  input wire logic cc1,
  output logic count_reached_event,
  output logic irq
);
  import ecu_pkg::*;

  initial begin
    if (CNT_W < 2 || CNT_W > ECU_DW) $error("ecu_counter: CNT_W out of range");
  end

  // reset release through two flops
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_sync_r <= 2'b00;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // cc1 edge pulses
  logic cc1_rise;
  logic cc1_fall;
  ecu_edge_sel u_cc1 (
    .clk(clk),
    .rst_n(rst_n),
    .line_in(cc1),
    .rise_p(cc1_rise),
    .fall_p(cc1_fall)
  );

  // registers and state
  logic [ECU_DW-1:0] ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0] term_r, term_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic [CNT_W-1:0] capt_r, capt_nxt;
  logic [ECU_IRQ_BITS-1:0] irq_stat_r, irq_stat_nxt;
  logic [ECU_IRQ_BITS-1:0] irq_mask_r, irq_mask_nxt;
  logic [ECU_DW-1:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  ecu_state_t state_r, state_nxt;
  logic [$clog2(ECU_TICK_CYC)-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_p;

  // control fields
  logic enabled;
  ecu_src_t start_src, inc_src, clr_src;
  ecu_edge_t start_edge, inc_edge, clr_edge;
  assign enabled = ctrl_r[ECU_CTRL_EN];
  assign start_src = ecu_src_t'(ctrl_r[ECU_CTRL_START_SRC +: 4]);
  assign start_edge = ecu_edge_t'(ctrl_r[ECU_CTRL_START_EDGE +: 2]);
  assign inc_src = ecu_src_t'(ctrl_r[ECU_CTRL_INC_SRC +: 4]);
  assign inc_edge = ecu_edge_t'(ctrl_r[ECU_CTRL_INC_EDGE +: 2]);
  assign clr_src = ecu_src_t'(ctrl_r[ECU_CTRL_CLR_SRC +: 4]);
  assign clr_edge = ecu_edge_t'(ctrl_r[ECU_CTRL_CLR_EDGE +: 2]);

  // cc1 edge qualified by an edge mode
  function automatic logic edge_hit(input ecu_edge_t mode, input logic r, input logic f);
    case (mode)
      ECU_EDGE_RISE: edge_hit = r;
      ECU_EDGE_FALL: edge_hit = f;
      ECU_EDGE_ANY: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // pick one event pulse by source code
  function automatic logic src_hit(input ecu_src_t src, input ecu_events_t ev,
                                   input logic line_p, input logic tick,
                                   input logic done);
    case (src)
      ECU_SRC_EXP_START: src_hit = ev.exp_start;
      ECU_SRC_EXP_END: src_hit = ev.exp_end;
      ECU_SRC_RD_START: src_hit = ev.rd_start;
      ECU_SRC_RD_END: src_hit = ev.rd_end;
      ECU_SRC_FRAME_START: src_hit = ev.frame_start;
      ECU_SRC_ACCEPTED: src_hit = ev.accepted_frame_trigger;
      ECU_SRC_REJECTED: src_hit = ev.rejected_frame_trigger;
      ECU_SRC_CC1: src_hit = line_p;
      ECU_SRC_TICK: src_hit = tick;
      ECU_SRC_TIMER_DONE: src_hit = ev.timer_done_event;
      ECU_SRC_COUNTER_DONE: src_hit = done;
      default: src_hit = 1'b0;
    endcase
  endfunction

  // microsecond tick divider
  always_comb begin
    tick_p = (tick_cnt_r == ($clog2(ECU_TICK_CYC))'(ECU_TICK_CYC - 1));
    tick_cnt_nxt = tick_p ? '0 : tick_cnt_r + 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_nxt;
  end

  // event qualification
  logic start_p, inc_p, clr_p, sw_clear, clear_any, inc_en;
  assign start_p = src_hit(start_src, events,
                           edge_hit(start_edge, cc1_rise, cc1_fall), 1'b0, done_r);
  assign inc_p = src_hit(inc_src, events,
                         edge_hit(inc_edge, cc1_rise, cc1_fall), tick_p, 1'b0);
  assign inc_en = inc_p && (inc_src != ECU_SRC_OFF);
  assign clr_p = src_hit(clr_src, events,
                         edge_hit(clr_edge, cc1_rise, cc1_fall), 1'b0, done_r);
  assign sw_clear = bus_req.wr && bus_req.addr == ECU_REG_CMD &&
                    bus_req.wdata[ECU_CMD_CLEAR];
  assign clear_any = sw_clear || (enabled && clr_p);

  // counting state machine
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    capt_nxt = capt_r;
    done_nxt = 1'b0;
    if (!enabled) begin
      state_nxt = ECU_ST_IDLE;
    end else begin
      case (state_r)
        ECU_ST_IDLE: begin
          if (start_src != ECU_SRC_OFF) state_nxt = ECU_ST_WAIT;
        end
        ECU_ST_WAIT: begin
          if (start_src == ECU_SRC_OFF) state_nxt = ECU_ST_IDLE;
          else if (start_p) begin
            state_nxt = ECU_ST_ACTIVE;
            count_nxt = '0;
          end
        end
        ECU_ST_ACTIVE: begin
          if (inc_en) begin
            count_nxt = count_r + 1'b1;
            if (count_r + 1'b1 == term_r) begin
              state_nxt = ECU_ST_DONE;
              done_nxt = 1'b1;
            end else if (count_r + 1'b1 == '1) begin
              state_nxt = ECU_ST_OVF;
            end
          end
        end
        default: ;
      endcase
    end
    if (clear_any) begin
      capt_nxt = count_r;
      count_nxt = '0;
      done_nxt = 1'b0;
      state_nxt = (enabled && start_src != ECU_SRC_OFF) ? ECU_ST_WAIT : ECU_ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ECU_ST_IDLE;
      count_r <= '0;
      capt_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      capt_r <= capt_nxt;
      done_r <= done_nxt;
    end
  end
  assign count_reached_event = done_r;

  // register file, interrupt status and read data
  logic [ECU_IRQ_BITS-1:0] irq_ev;
  assign irq_ev[ECU_IRQ_DONE] = done_nxt;
  assign irq_ev[ECU_IRQ_OVF] = (state_nxt == ECU_ST_OVF) && (state_r != ECU_ST_OVF);

  always_comb begin
    ctrl_nxt = ctrl_r;
    term_nxt = term_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    rdata_nxt = '0;
    if (bus_req.wr) begin
      if (bus_req.addr == ECU_REG_CTRL) begin
        // configuration fields only change while disabled
        if (!enabled) ctrl_nxt = bus_req.wdata;
        else ctrl_nxt[ECU_CTRL_EN] = bus_req.wdata[ECU_CTRL_EN];
      end else if (bus_req.addr == ECU_REG_TERM) begin
        if (!enabled) term_nxt = bus_req.wdata[CNT_W-1:0];
      end else if (bus_req.addr == ECU_REG_MASK) begin
        irq_mask_nxt = bus_req.wdata[ECU_IRQ_BITS-1:0];
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == ECU_REG_CTRL) rdata_nxt = ctrl_r;
      else if (bus_req.addr == ECU_REG_TERM) rdata_nxt = ECU_DW'(term_r);
      else if (bus_req.addr == ECU_REG_STAT) rdata_nxt = ECU_DW'(state_r);
      else if (bus_req.addr == ECU_REG_VALUE) rdata_nxt = ECU_DW'(count_r);
      else if (bus_req.addr == ECU_REG_CAPT) rdata_nxt = ECU_DW'(capt_r);
      else if (bus_req.addr == ECU_REG_IRQ) begin
        rdata_nxt = ECU_DW'(irq_stat_r);
        irq_stat_nxt = '0;
      end else if (bus_req.addr == ECU_REG_MASK) rdata_nxt = ECU_DW'(irq_mask_r);
      else rdata_nxt = '0;
    end
    // a new event wins over the read clear
    irq_stat_nxt = irq_stat_nxt | irq_ev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= ECU_CTRL_RST;
      term_r <= ECU_TERM_RST[CNT_W-1:0];
      irq_mask_r <= '0;
      irq_stat_r <= '0;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      term_r <= term_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

// File: ecu_counter_checker.sv
// ecu_counter_checker: port-level assertions for the event counter
// assumes it is bound to ecu_counter and sees only its ports
`default_nettype none
module ecu_counter_checker #(
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ecu_pkg::ecu_bus_req_t bus_req,
  input wire logic [ecu_pkg::ECU_DW-1:0] rdata,
  input wire ecu_pkg::ecu_events_t events,
  input wire logic cc1,
  input wire logic count_reached_event,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ecu_pkg::*;
  logic rd_q;
  logic [ECU_AW-1:0] a_q;
  // read strobe and address of the previous cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 1'b0;
      a_q <= '0;
    end else begin
      rd_q <= bus_req.rd;
      a_q <= bus_req.addr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!rd_q |-> rdata == '0) else $error("rdata not zero");
  a_unmapped_zero: assert property (rd_q && a_q inside {4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hd}
    |-> rdata == '0) else $error("unmapped read not zero");
  a_state_code: assert property (rd_q && a_q == ECU_REG_STAT |-> rdata <= 32'h4)
    else $error("state code out of range");
  a_value_width: assert property (rd_q && a_q == ECU_REG_VALUE |-> (rdata >> CNT_W) == 0)
    else $error("count wider than counter");
  a_capt_width: assert property (rd_q && a_q == ECU_REG_CAPT |-> (rdata >> CNT_W) == 0)
    else $error("captured value too wide");
  a_reach_pulse: assert property (count_reached_event |=> !count_reached_event)
    else $error("end event longer than one cycle");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(bus_req.rd || bus_req.wr))
    else $error("irq dropped without access");
  a_reset_quiet: assert property ($rose(rstn) |-> (!count_reached_event && !irq)[*2])
    else $error("outputs active after reset");
  // main scenarios reached
  c_reach: cover property (count_reached_event);
  c_irq_clear: cover property ($fell(irq));
  c_read_data: cover property (rd_q && rdata != '0);
endmodule
bind ecu_counter ecu_counter_checker #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rstn(rstn),
  .bus_req(bus_req), .rdata(rdata), .events(events), .cc1(cc1),
  .count_reached_event(count_reached_event), .irq(irq));
`default_nettype wire

// File: ecu_edge_sel.sv
// ecu_edge_sel: synchronises the cc1 line and gives rise and fall pulses
// assumes cc1 is asynchronous to clk
`default_nettype none
module ecu_edge_sel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_in,
  output logic rise_p,
  output logic fall_p
);
  import ecu_pkg::*;
  logic [ECU_SYNC_STAGES-1:0] sync_r;
  logic [ECU_SYNC_STAGES-1:0] sync_nxt;
  logic last_r;
  logic last_nxt;

  // two-stage synchroniser, then a history bit for edge detection
  always_comb begin
    sync_nxt = {sync_r[ECU_SYNC_STAGES-2:0], line_in};
    last_nxt = sync_r[ECU_SYNC_STAGES-1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= '0;
      last_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // one pulse per qualifying transition
  assign rise_p = sync_r[ECU_SYNC_STAGES-1] & ~last_r;
  assign fall_p = ~sync_r[ECU_SYNC_STAGES-1] & last_r;
endmodule
`default_nettype wire

// File: ecu_pkg.sv
// ecu_pkg: constants, register map and types for the event counter unit
// assumes a single 100 MHz clock domain and a simple strobe register port
`default_nettype none
package ecu_pkg;
  localparam int ECU_AW = 4;
  localparam int ECU_DW = 32;
  // register byte offsets
  localparam logic [ECU_AW-1:0] ECU_REG_CTRL = 4'h0;
  localparam logic [ECU_AW-1:0] ECU_REG_TERM = 4'h4;
  localparam logic [ECU_AW-1:0] ECU_REG_STAT = 4'h8;
  localparam logic [ECU_AW-1:0] ECU_REG_VALUE = 4'hc;
  // second bank at offsets 1, 2, 3 and 5 in the lower half of the map
  localparam logic [ECU_AW-1:0] ECU_REG_CAPT = 4'h1;
  localparam logic [ECU_AW-1:0] ECU_REG_CMD = 4'h2;
  localparam logic [ECU_AW-1:0] ECU_REG_IRQ = 4'h3;
  localparam logic [ECU_AW-1:0] ECU_REG_MASK = 4'h5;
  // control field positions
  localparam int ECU_CTRL_EN = 0;
  localparam int ECU_CTRL_START_SRC = 4;
  localparam int ECU_CTRL_START_EDGE = 8;
  localparam int ECU_CTRL_INC_SRC = 12;
  localparam int ECU_CTRL_INC_EDGE = 16;
  localparam int ECU_CTRL_CLR_SRC = 20;
  localparam int ECU_CTRL_CLR_EDGE = 24;
  localparam int ECU_CMD_CLEAR = 0;
  localparam int ECU_IRQ_BITS = 2;
  localparam int ECU_IRQ_DONE = 0;
  localparam int ECU_IRQ_OVF = 1;
  // reset values
  localparam logic [ECU_DW-1:0] ECU_CTRL_RST = 32'h0000_0000;
  localparam logic [ECU_DW-1:0] ECU_TERM_RST = 32'h0000_0001;
  // microsecond tick at 100 MHz
  localparam int ECU_CLK_MHZ = 100;
  localparam int ECU_TICK_US = 1;
  localparam int ECU_TICK_CYC = ECU_TICK_US * ECU_CLK_MHZ;
  localparam int ECU_SYNC_STAGES = 2;

  // event sources shared by start, increment and clear selectors
  typedef enum logic [3:0] {
    ECU_SRC_OFF, ECU_SRC_EXP_START, ECU_SRC_EXP_END, ECU_SRC_RD_START,
    ECU_SRC_RD_END, ECU_SRC_FRAME_START, ECU_SRC_ACCEPTED, ECU_SRC_REJECTED,
    ECU_SRC_CC1, ECU_SRC_TICK, ECU_SRC_TIMER_DONE, ECU_SRC_COUNTER_DONE
  } ecu_src_t;

  typedef enum logic [1:0] {
    ECU_EDGE_RISE, ECU_EDGE_FALL, ECU_EDGE_ANY
  } ecu_edge_t;

  typedef enum logic [2:0] {
    ECU_ST_IDLE, ECU_ST_WAIT, ECU_ST_ACTIVE, ECU_ST_DONE, ECU_ST_OVF
  } ecu_state_t;

  // single-cycle internal event pulses from the camera logic
  typedef struct packed {
    logic exp_start;
    logic exp_end;
    logic rd_start;
    logic rd_end;
    logic frame_start;
    logic accepted_frame_trigger;
    logic rejected_frame_trigger;
    logic timer_done_event;
  } ecu_events_t;

  // register port request
  typedef struct packed {
    logic [ECU_AW-1:0] addr;
    logic [ECU_DW-1:0] wdata;
    logic wr;
    logic rd;
  } ecu_bus_req_t;
endpackage
`default_nettype wire

// File: test_event_counter_unit.sv
// test_event_counter_unit: self-checking bench for the event counter
// assumes ecu_cam_model drives the camera events and the cc1 line
`default_nettype none
module test_event_counter_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import ecu_pkg::*;
  logic clk, rstn, cre, irq, cc1;
  logic [31:0] rdata;
  ecu_bus_req_t req;
  ecu_events_t ev;
  int bad_count = 0;
  int n_compared = 0;
  int hits = 0;
  ecu_counter #(.CNT_W(8)) uut (.clk(clk), .rstn(rstn), .bus_req(req), .rdata(rdata),
    .events(ev), .cc1(cc1), .count_reached_event(cre), .irq(irq));
  ecu_cam_model cam (.clk(clk), .events(ev), .cc1(cc1));
  // clock and end event monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (cre === 1'b1) hits <= hits + 1;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rc(string n, logic [3:0] a, logic [31:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  function automatic logic [31:0] mk(int st, se, is, ie, cs, ce);
    return 32'(st << 4 | se << 8 | is << 12 | ie << 16 | cs << 20 | ce << 24 | 1);
  endfunction
  function automatic int bt(int s);
    return s == 10 ? 0 : 8 - s;
  endfunction
  // disable, clear, set terminal count, enable
  task automatic cfg(logic [31:0] c, logic [31:0] t);
    wr(ECU_REG_CTRL, 32'h0);
    wr(ECU_REG_CMD, 32'h1);
    wr(ECU_REG_TERM, t);
    wr(ECU_REG_CTRL, c);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_off();
    cfg(mk(5, 0, 0, 0, 0, 0), 32'h3);
    for (int b = 0; b < 8; b++) cam.pulse(b);
    rc("value off", ECU_REG_VALUE, 32'h0);
  endtask
  task automatic t_internal();
    int s[8] = '{1, 2, 3, 4, 5, 6, 7, 10};
    int h;
    foreach (s[i]) begin
      cfg(mk(s[i] == 5 ? 1 : 5, 0, s[i], 0, 0, 0), 32'h3);
      h = hits;
      cam.pulse(bt(s[i] == 5 ? 1 : 5));
      repeat (3) cam.pulse(bt(s[i]));
      rc("value", ECU_REG_VALUE, 32'h3);
      rc("state", ECU_REG_STAT, 32'h3);
      chk("reached", 32'(h + 1), 32'(hits));
    end
  endtask
  task automatic t_cc1();
    for (int e = 0; e < 3; e++) begin
      cfg(mk(8, e, 9, 0, 0, 0), 32'hf0);
      cam.line(1);
      rc("start", ECU_REG_STAT, e == 1 ? 32'h1 : 32'h2);
      cam.line(0);
      cfg(mk(5, 0, 8, e, 0, 0), 32'hf0);
      cam.pulse(3);
      repeat (2) cam.line(1);
      cam.line(0);
      cam.line(1);
      cam.line(0);
      rc("cc1 count", ECU_REG_VALUE, e == 2 ? 32'h4 : 32'h2);
      cfg(mk(1, 0, 2, 0, 8, e), 32'hf0);
      cam.pulse(7);
      repeat (2) cam.pulse(6);
      cam.line(1);
      rc("cc1 clear", ECU_REG_VALUE, e == 1 ? 32'h2 : 32'h0);
      cam.line(0);
      rc("cc1 clear", ECU_REG_VALUE, 32'h0);
    end
  endtask
  task automatic t_tick();
    logic [31:0] v;
    cfg(mk(5, 0, 9, 0, 0, 0), 32'hf0);
    cam.pulse(3);
    repeat (1000) @(posedge clk);
    @(posedge clk);
    req <= '{addr: ECU_REG_VALUE, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
    chk("ticks", 32'h1, 32'(v >= 9 && v <= 11));
  endtask
  task automatic t_clear();
    int c[9] = '{1, 2, 3, 4, 5, 6, 7, 10, 11};
    foreach (c[i]) begin
      cfg(mk(8, 0, c[i] == 2 ? 3 : 2, 0, c[i], 0), 32'h2);
      cam.line(1);
      repeat (2) cam.pulse(bt(c[i] == 2 ? 3 : 2));
      if (c[i] != 11) cam.pulse(bt(c[i]));
      rc("captured", ECU_REG_CAPT, 32'h2);
      rc("rewait", ECU_REG_STAT, 32'h1);
      cam.line(0);
    end
    cfg(mk(1, 0, 2, 0, 0, 0), 32'hf0);
    cam.pulse(7);
    for (int b = 7; b >= 0; b--) cam.pulse(b);
    rc("no clear", ECU_REG_VALUE, 32'h1);
    wr(ECU_REG_CMD, 32'h1);
    rc("soft capt", ECU_REG_CAPT, 32'h1);
  endtask
  task automatic t_irq();
    wr(ECU_REG_MASK, 32'h1);
    rc("irq stat", ECU_REG_IRQ, 32'h1);
    chk("irq low", 32'h0, 32'(irq));
    cfg(mk(5, 0, 2, 0, 0, 0), 32'h1);
    cam.pulse(3);
    cam.pulse(6);
    repeat (2) @(posedge clk);
    chk("irq high", 32'h1, 32'(irq));
    wr(ECU_REG_MASK, 32'h0);
    #1 chk("irq masked", 32'h0, 32'(irq));
  endtask
  // run up to the top of an 8-bit count with no terminal match
  task automatic t_ovf();
    cfg(mk(5, 0, 2, 0, 0, 0), 32'h0);
    cam.pulse(3);
    repeat (255) cam.pulse(6);
    rc("overflow", ECU_REG_STAT, 32'h4);
    rc("ovf irq", ECU_REG_IRQ, 32'h3);
  endtask
  task automatic close_out();
    $display("errors %0d compared %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    rstn = 1'b0;
    req = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rc("term", ECU_REG_TERM, 32'h1);
    rc("idle", ECU_REG_STAT, 32'h0);
    rc("unmapped", 4'h6, 32'h0);
    t_off();
    t_internal();
    t_cc1();
    t_tick();
    t_clear();
    t_irq();
    t_ovf();
    close_out();
  end
  // hang guard
  initial begin
    #300us;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
